//--- bus_program_delay_router.sv
`timescale 1ns/1ps
// Summary of operation
// - Some programming actions delay ready-for-data by a function-specific time.
// - Frequency programming withholds ready-for-data for 5 ms.
// - Attenuation programming withholds ready-for-data for 50 ms.
// - FM calibration withholds ready-for-data while the busy flag is asserted.
// - A 4-bit register holds each nibble; data nibbles feed the control unit.
// - An address nibble raises select enable, gating it into the selector.
// - After an address, the holding register clock is blocked for 100 us.
// - A strap disables the 100 us address clock inhibit.
// - Selector decodes one of ten functions; plug-in strobe loads it.
// - While power hold-off is low, all programming logic stays inhibited.
// - Hold-off sets frequency to 1 MHz and attenuation to -140 dB; release pulses init.
// - Accepted state holds until data-valid and busy clear, then goes idle.
// - Device clear performs the same initialization as power hold-off.
module bus_program_delay_router #(
    parameter int FREQ_DELAY_CYC   = bpdr_pkg::FREQ_DELAY_CYC,
    parameter int ATTEN_DELAY_CYC  = bpdr_pkg::ATTEN_DELAY_CYC,
    parameter int ADDR_INHIBIT_CYC = bpdr_pkg::ADDR_INHIBIT_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire bpdr_pkg::bpdr_bus_req_t      busReq,
    output logic [31:0]                       regRdData,
    input  wire bpdr_pkg::bpdr_link_in_t      linkIn,
    input  wire logic                         controlBusy,
    input  wire logic                         powerHoldoff_n,
    input  wire logic                         device_clear_pulse_n,
    input  wire logic                         address_inhibit_strap,
    output logic                              readyForData,
    output logic                              dataAccepted,
    output logic [3:0]                        digital_control_unit_data,
    output logic                              digital_control_unit_strobe,
    output logic                              select_enable,
    output logic [bpdr_pkg::NUM_FUNC-1:0]     functionSelect,
    output logic                              plugin_strobe_n,
    output logic [bpdr_pkg::NUM_FUNC-1:0][3:0] functionReg,
    output logic                              initPulse
);

    typedef struct packed {
        bpdr_pkg::bpdr_hs_t                   hs;
        logic [3:0]                           holding;
        logic                                 heldIsAddress;
        logic [3:0]                           lastData;
        logic [bpdr_pkg::CNT_W-1:0]           settleCnt;
        logic [bpdr_pkg::CNT_W-1:0]           inhibitCnt;
        logic                                 fmcalWait;
        logic                                 holdoffSeen;
        logic [1:0]                           ctrl;
        logic [3:0]                           lastFunc;
        logic [31:0]                          rdData;
        logic                                 rfd;
        logic                                 dac;
        logic [3:0]                           dcuData;
        logic                                 dcuStrobe;
        logic                                 selEnable;
        logic [bpdr_pkg::NUM_FUNC-1:0]        funcSel;
        logic                                 pickStrobe_n;
        logic [bpdr_pkg::NUM_FUNC-1:0][3:0]   funcReg;
        logic                                 initP;
    } bpdr_state_t;

    bpdr_state_t s;
    bpdr_state_t next_s;

    logic [bpdr_pkg::NUM_FUNC-1:0]       decodeHit;
    logic [bpdr_pkg::NUM_FUNC-1:0][3:0]  next_funcReg;
    logic [bpdr_pkg::NUM_FUNC-1:0][3:0]  initReg;
    logic                                initNow;
    logic                                busyGated;
    logic                                inhibitActive;
    logic                                anyHold;
    logic                                strobeNow;
    logic [7:0]                          funcOffset;
    logic                                funcAddrHit;
    logic [3:0]                          funcIdx;

    // Function registers sit four bytes apart above the base
    assign funcOffset  = busReq.addr - bpdr_pkg::REG_FUNC_BASE;
    assign funcAddrHit = (busReq.addr >= bpdr_pkg::REG_FUNC_BASE)
                         && (funcOffset[1:0] == 2'h0)
                         && (funcOffset < 8'(bpdr_pkg::NUM_FUNC * 4));
    assign funcIdx     = funcOffset[5:2];

    // device clear and hold-off share one initialization path
    assign initNow = !device_clear_pulse_n || !powerHoldoff_n;

    assign busyGated = controlBusy && s.ctrl[bpdr_pkg::CTRL_BUSY_COUPLE];

    // strap bypasses the address clock inhibit
    assign inhibitActive = (s.inhibitCnt != '0) && !address_inhibit_strap;

    // every delay source must be clear
    assign anyHold = (s.settleCnt != '0) || busyGated || inhibitActive
                     || (s.fmcalWait && controlBusy);

    // Plug-in strobe fires in the transfer state of an address nibble
    assign strobeNow = (s.hs == bpdr_pkg::BPDR_TRANSFER) && s.heldIsAddress;

    // one-of-ten selector and per-function register load
    genvar gi;
    generate
        for (gi = 0; gi < bpdr_pkg::NUM_FUNC; gi++) begin : g_func
            assign decodeHit[gi] = (s.holding == 4'(gi)) && s.heldIsAddress;
            // power-up codes for frequency and attenuation
            assign initReg[gi] =
                (4'(gi) == bpdr_pkg::FUNC_FREQ)  ? bpdr_pkg::FREQ_INIT_CODE :
                (4'(gi) == bpdr_pkg::FUNC_ATTEN) ? bpdr_pkg::ATTEN_INIT_CODE :
                bpdr_pkg::FUNC_RESET_CODE;
            // route data to the addressed register on the strobe
            assign next_funcReg[gi] = (strobeNow && decodeHit[gi])
                                      ? s.lastData : s.funcReg[gi];
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.dcuStrobe = 1'b0;
        next_s.pickStrobe_n = 1'b1;
        next_s.initP = 1'b0;
        next_s.funcReg = next_funcReg;

        // counters run down on the system clock
        if (s.settleCnt != '0) begin
            next_s.settleCnt = s.settleCnt - 1'b1;
        end
        if (s.inhibitCnt != '0) begin
            next_s.inhibitCnt = s.inhibitCnt - 1'b1;
        end
        if (s.fmcalWait && !controlBusy && s.hs == bpdr_pkg::BPDR_IDLE) begin
            next_s.fmcalWait = 1'b0;
        end

        unique case (s.hs)
            bpdr_pkg::BPDR_IDLE: begin
                // holding register loads only when the clock is free
                if (linkIn.dataValid && s.rfd) begin
                    next_s.holding = linkIn.nibble;
                    // nibble captured into the holding register
                    next_s.heldIsAddress = linkIn.isAddress;
                    next_s.hs = bpdr_pkg::BPDR_STORE;
                end
            end
            bpdr_pkg::BPDR_STORE: begin
                if (s.heldIsAddress) begin
                    // address nibble gated into the selector
                    next_s.selEnable = 1'b1;
                    next_s.funcSel = decodeHit;
                    next_s.inhibitCnt =
                        bpdr_pkg::CNT_W'(ADDR_INHIBIT_CYC);
                end else begin
                    // data nibble goes straight to the control unit
                    next_s.dcuData = s.holding;
                    next_s.lastData = s.holding;
                end
                next_s.hs = bpdr_pkg::BPDR_TRANSFER;
            end
            bpdr_pkg::BPDR_TRANSFER: begin
                if (s.heldIsAddress) begin
                    next_s.pickStrobe_n = 1'b0;
                    next_s.lastFunc = s.holding;
                    if (s.ctrl[bpdr_pkg::CTRL_DELAY_EN]) begin
                        unique case (s.holding)
                            bpdr_pkg::FUNC_FREQ: begin
                                next_s.settleCnt =
                                    bpdr_pkg::CNT_W'(FREQ_DELAY_CYC);
                            end
                            bpdr_pkg::FUNC_ATTEN: begin
                                next_s.settleCnt =
                                    bpdr_pkg::CNT_W'(ATTEN_DELAY_CYC);
                            end
                            // wait on the control unit busy flag
                            bpdr_pkg::FUNC_FMCAL: begin
                                next_s.fmcalWait = 1'b1;
                            end
                            default: begin
                                next_s.settleCnt = s.settleCnt;
                            end
                        endcase
                    end
                end else begin
                    next_s.dcuStrobe = 1'b1;
                end
                next_s.hs = bpdr_pkg::BPDR_ACCEPTED;
            end
            bpdr_pkg::BPDR_ACCEPTED: begin
                next_s.selEnable = 1'b0;
                // leave only when data-valid and busy are released
                if (!linkIn.dataValid && !busyGated) begin
                    next_s.hs = bpdr_pkg::BPDR_IDLE;
                end
            end
        endcase

        next_s.rfd = (next_s.hs == bpdr_pkg::BPDR_IDLE) && !anyHold
                     && (next_s.settleCnt == '0) && !next_s.fmcalWait
                     && !(linkIn.dataValid && s.rfd);
        next_s.dac = (next_s.hs == bpdr_pkg::BPDR_ACCEPTED);

        // Register writes
        if (busReq.wr && busReq.addr == bpdr_pkg::REG_CTRL) begin
            next_s.ctrl = busReq.wrData[1:0];
        end

        // Register reads, answered one cycle later
        next_s.rdData = '0;
        if (busReq.rd) begin
            if (busReq.addr == bpdr_pkg::REG_CTRL) begin
                next_s.rdData = {30'h0, s.ctrl};
            end else if (busReq.addr == bpdr_pkg::REG_STATUS) begin
                next_s.rdData[1:0] = s.hs;
                next_s.rdData[2]   = s.rfd;
                next_s.rdData[3]   = s.dac;
                next_s.rdData[4]   = controlBusy;
                next_s.rdData[5]   = (s.settleCnt != '0);
                next_s.rdData[6]   = inhibitActive;
                next_s.rdData[7]   = s.fmcalWait;
            end else if (busReq.addr == bpdr_pkg::REG_FUNCSEL) begin
                next_s.rdData[3:0]  = s.lastFunc;
                next_s.rdData[15:6] = s.funcSel;
            end else if (funcAddrHit) begin
                next_s.rdData[3:0] = s.funcReg[funcIdx];
            end
        end

        // hold-off and device clear inhibit and reinitialize
        if (initNow) begin
            next_s.hs = bpdr_pkg::BPDR_IDLE;
            next_s.rfd = 1'b0;
            next_s.dac = 1'b0;
            next_s.selEnable = 1'b0;
            next_s.funcSel = '0;
            next_s.dcuStrobe = 1'b0;
            next_s.pickStrobe_n = 1'b1;
            next_s.settleCnt = '0;
            next_s.inhibitCnt = '0;
            next_s.fmcalWait = 1'b0;
            next_s.funcReg = initReg;
            next_s.holdoffSeen = 1'b1;
        end else if (s.holdoffSeen) begin
            // Release of the hold-off announces the initialization
            next_s.holdoffSeen = 1'b0;
            next_s.initP = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '{hs: bpdr_pkg::BPDR_IDLE,
                   holding: 4'h0,
                   heldIsAddress: 1'b0,
                   lastData: 4'h0,
                   settleCnt: '0,
                   inhibitCnt: '0,
                   fmcalWait: 1'b0,
                   holdoffSeen: 1'b1,
                   ctrl: bpdr_pkg::CTRL_RESET,
                   lastFunc: 4'h0,
                   rdData: 32'h0,
                   rfd: 1'b0,
                   dac: 1'b0,
                   dcuData: 4'h0,
                   dcuStrobe: 1'b0,
                   selEnable: 1'b0,
                   funcSel: '0,
                   pickStrobe_n: 1'b1,
                   funcReg: '0,
                   initP: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign regRdData                   = s.rdData;
    assign readyForData                = s.rfd;
    assign dataAccepted                = s.dac;
    assign digital_control_unit_data   = s.dcuData;
    assign digital_control_unit_strobe = s.dcuStrobe;
    assign select_enable               = s.selEnable;
    assign functionSelect              = s.funcSel;
    assign plugin_strobe_n             = s.pickStrobe_n;
    assign functionReg                 = s.funcReg;
    assign initPulse                   = s.initP;

endmodule : bus_program_delay_router

//--- bpdr_pkg.sv
package bpdr_pkg;

    // System clock and the settling times that withhold ready-for-data
    localparam int CLK_HZ           = 100_000_000;
    localparam int FREQ_DELAY_US    = 5_000;
    localparam int ATTEN_DELAY_US   = 50_000;
    localparam int ADDR_INHIBIT_US  = 100;
    localparam int FMCAL_DELAY_S    = 5;
    localparam int FREQ_DELAY_CYC   = FREQ_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int ATTEN_DELAY_CYC  = ATTEN_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int ADDR_INHIBIT_CYC = ADDR_INHIBIT_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W            = 23;

    // Function selector: ten programming functions
    localparam int NUM_FUNC         = 10;
    localparam logic [3:0] FUNC_FREQ   = 4'h0;
    localparam logic [3:0] FUNC_ATTEN  = 4'h1;
    localparam logic [3:0] FUNC_FMCAL  = 4'h2;

    // Power-up values: 1 MHz and -140 dB, encoded as function nibbles
    localparam int FREQ_INIT_MHZ    = 1;
    localparam int ATTEN_INIT_DB    = -140;
    localparam logic [3:0] FREQ_INIT_CODE  = 4'h1;
    localparam logic [3:0] ATTEN_INIT_CODE = 4'he;
    localparam logic [3:0] FUNC_RESET_CODE = 4'h0;

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_FUNCSEL   = 8'h08;
    localparam logic [7:0] REG_FUNC_BASE = 8'h10;
    localparam int CTRL_BUSY_COUPLE  = 0;
    localparam int CTRL_DELAY_EN     = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Handshake states, held in two flip-flops as codes 00/01/10/11
    typedef enum logic [1:0] {
        BPDR_IDLE,
        BPDR_STORE,
        BPDR_TRANSFER,
        BPDR_ACCEPTED
    } bpdr_hs_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wrData;
        logic        wr;
        logic        rd;
    } bpdr_bus_req_t;

    typedef struct packed {
        logic [3:0] nibble;
        logic       isAddress;
        logic       dataValid;
    } bpdr_link_in_t;

endpackage : bpdr_pkg

//--- bpdr_ctrl_model.sv
`timescale 1ns/1ps
module bpdr_ctrl_model (
    input  wire logic               clk,
    input  wire logic               readyForData,
    input  wire logic               dataAccepted,
    output bpdr_pkg::bpdr_link_in_t linkIn
);
    initial linkIn = '0;
    task automatic send(input logic [3:0] nib, input logic isAdr,
                        input int slow, output logic ok);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (readyForData !== 1'b1 && i < 5000);
        linkIn <= '{nibble: nib, isAddress: isAdr, dataValid: 1'b1};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (dataAccepted !== 1'b1 && i < 50);
        ok = readyForData !== 1'b1 && dataAccepted === 1'b1;
        repeat (slow) @(posedge clk);
        // Released lines carry garbage, not the old nibble
        linkIn <= '{nibble: ~nib, isAddress: ~isAdr, dataValid: 1'b0};
    endtask : send
endmodule : bpdr_ctrl_model

//--- bpdr_chk.sv
`timescale 1ns/1ps
module bpdr_chk #(
    parameter int FREQ_DELAY_CYC   = 50,
    parameter int ATTEN_DELAY_CYC  = 500,
    parameter int ADDR_INHIBIT_CYC = 20
) (
    input wire logic                               clk,
    input wire logic                               reset,
    input wire logic                               controlBusy,
    input wire logic                               powerHoldoff_n,
    input wire logic                               device_clear_pulse_n,
    input wire logic                               address_inhibit_strap,
    input wire logic                               readyForData,
    input wire logic                               select_enable,
    input wire logic [bpdr_pkg::NUM_FUNC-1:0]      functionSelect,
    input wire logic                               plugin_strobe_n,
    input wire logic [bpdr_pkg::NUM_FUNC-1:0][3:0] functionReg,
    input wire logic                               initPulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [31:0] sinceAddr;
    // Cycles since the last plug-in strobe, saturating
    always_ff @(posedge clk) begin
        if (reset || !powerHoldoff_n || !device_clear_pulse_n) begin
            sinceAddr <= 32'hffff;
        end else if (!plugin_strobe_n) begin
            sinceAddr <= 32'h0;
        end else if (sinceAddr < 32'hffff) begin
            sinceAddr <= sinceAddr + 32'h1;
        end
    end
    property p_freq_hold;
        readyForData && functionSelect[0]
            |-> sinceAddr >= FREQ_DELAY_CYC - 3;
    endproperty
    a_freq_hold: assert property (p_freq_hold)
        else $error("ready too soon after frequency");
    property p_atten_hold;
        readyForData && functionSelect[1]
            |-> sinceAddr >= ATTEN_DELAY_CYC - 3;
    endproperty
    a_atten_hold: assert property (p_atten_hold)
        else $error("ready too soon after attenuation");
    property p_addr_inhibit;
        readyForData && !address_inhibit_strap
            |-> sinceAddr >= ADDR_INHIBIT_CYC - 3;
    endproperty
    a_addr_inhibit: assert property (p_addr_inhibit)
        else $error("ready too soon after address");
    property p_fm_busy;
        functionSelect[2] && controlBusy && $past(controlBusy)
            |-> !readyForData;
    endproperty
    a_fm_busy: assert property (p_fm_busy)
        else $error("ready while calibration busy");
    property p_holdoff;
        !powerHoldoff_n && !$past(powerHoldoff_n) |-> !readyForData;
    endproperty
    a_holdoff: assert property (p_holdoff)
        else $error("ready during power hold-off");
    property p_clear_init;
        !device_clear_pulse_n && !$past(device_clear_pulse_n)
            |-> functionReg[0] == bpdr_pkg::FREQ_INIT_CODE
                && functionReg[1] == bpdr_pkg::ATTEN_INIT_CODE;
    endproperty
    a_clear_init: assert property (p_clear_init)
        else $error("clear did not restore presets");
    property p_init_pulse;
        $rose(powerHoldoff_n) && device_clear_pulse_n |-> ##[0:2] initPulse;
    endproperty
    a_init_pulse: assert property (p_init_pulse)
        else $error("no init pulse after hold-off");
    property p_sel_strobe;
        $rose(select_enable) |-> ##[0:1] !plugin_strobe_n;
    endproperty
    a_sel_strobe: assert property (p_sel_strobe)
        else $error("select enable without plug-in strobe");
endmodule : bpdr_chk
bind bus_program_delay_router bpdr_chk #(
    .FREQ_DELAY_CYC(FREQ_DELAY_CYC),
    .ATTEN_DELAY_CYC(ATTEN_DELAY_CYC),
    .ADDR_INHIBIT_CYC(ADDR_INHIBIT_CYC)
) u_chk (
    .clk(clk),
    .reset(reset),
    .controlBusy(controlBusy),
    .powerHoldoff_n(powerHoldoff_n),
    .device_clear_pulse_n(device_clear_pulse_n),
    .address_inhibit_strap(address_inhibit_strap),
    .readyForData(readyForData),
    .select_enable(select_enable),
    .functionSelect(functionSelect),
    .plugin_strobe_n(plugin_strobe_n),
    .functionReg(functionReg),
    .initPulse(initPulse)
);

//--- tb_bus_program_delay_router.sv
`timescale 1ns/1ps
module tb_bus_program_delay_router;
    localparam int FD = 50;
    localparam int AD = 500;
    localparam int ID = 20;
    logic clk, reset, controlBusy, powerHoldoff_n, clearN, strap, rfd, dac;
    logic dcuStb, selEn, pickN, initPulse;
    logic [3:0] dcuData;
    logic [9:0] funcSel;
    logic [9:0][3:0] funcReg;
    logic [31:0] rdData;
    bpdr_pkg::bpdr_bus_req_t busReq;
    bpdr_pkg::bpdr_link_in_t linkIn;
    int n_fail, samples_checked, n;
    bus_program_delay_router #(.FREQ_DELAY_CYC(FD), .ATTEN_DELAY_CYC(AD),
        .ADDR_INHIBIT_CYC(ID)) DUT (.clk(clk), .reset(reset), .busReq(busReq),
        .regRdData(rdData), .linkIn(linkIn), .controlBusy(controlBusy),
        .powerHoldoff_n(powerHoldoff_n), .device_clear_pulse_n(clearN),
        .address_inhibit_strap(strap), .readyForData(rfd), .dataAccepted(dac),
        .digital_control_unit_data(dcuData),
        .digital_control_unit_strobe(dcuStb),
        .select_enable(selEn), .functionSelect(funcSel),
        .plugin_strobe_n(pickN),
        .functionReg(funcReg), .initPulse(initPulse));
    bpdr_ctrl_model ctl (.clk(clk), .readyForData(rfd), .dataAccepted(dac),
        .linkIn(linkIn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task send(input logic [3:0] nib, input logic isAdr, input int slow);
        logic ok;
        ctl.send(nib, isAdr, slow, ok);
        chk(32'(ok), 32'h1);
        if (ok !== 1'b1) finish_test;
    endtask : send
    task waitRfd;
        n = 0;
        while (rfd !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            n_fail++;
            $display("ERROR t=%0t ready-for-data never came", $time);
            finish_test;
        end
    endtask : waitRfd
    task rdReg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) busReq <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) busReq.rd <= 1'b0;
        #1 chk(rdData, exp);
    endtask : rdReg
    task t_power;
        repeat (5) @(posedge clk);
        chk(32'(rfd), 32'h0);
        powerHoldoff_n <= 1'b1;
        n = 0;
        repeat (4) begin
            @(posedge clk);
            if (initPulse === 1'b1) n = 1;
        end
        chk(n, 1);
        chk(32'(funcReg[0]), 32'(bpdr_pkg::FREQ_INIT_CODE));
        chk(32'(funcReg[1]), 32'(bpdr_pkg::ATTEN_INIT_CODE));
        send(4'ha, 1'b0, 2);
        chk(32'(dcuData), 32'ha);
        $display("power-up and data test done");
    endtask : t_power
    task t_func;
        int d;
        for (int f = 0; f < 10; f++) begin
            d = f == 0 ? FD : (f == 1 ? AD : ID);
            send(4'(f + 3), 1'b0, f % 3);
            send(4'(f), 1'b1, 0);
            chk(32'(funcSel), 32'h1 << f);
            chk(32'(funcReg[f]), 32'(f + 3));
            waitRfd;
            chk(32'(n + 6 >= d && n <= d + 3), 32'h1);
        end
        strap <= 1'b1;
        send(4'h7, 1'b0, 0);
        send(4'h5, 1'b1, 0);
        waitRfd;
        chk(32'(n < 6), 32'h1);
        repeat (ID) @(posedge clk);
        strap <= 1'b0;
        $display("function and delay test done");
    endtask : t_func
    task t_fmcal;
        send(4'h9, 1'b0, 0);
        send(bpdr_pkg::FUNC_FMCAL, 1'b1, 0);
        controlBusy <= 1'b1;
        n = 0;
        repeat (100) begin
            @(posedge clk);
            if (rfd !== 1'b0) n++;
        end
        chk(n, 0);
        controlBusy <= 1'b0;
        waitRfd;
        chk(32'(n < 6), 32'h1);
        $display("calibration test done");
    endtask : t_fmcal
    task t_clear;
        clearN <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(rfd), 32'h0);
        chk(32'(funcReg[0]), 32'(bpdr_pkg::FREQ_INIT_CODE));
        chk(32'(funcReg[1]), 32'(bpdr_pkg::ATTEN_INIT_CODE));
        clearN <= 1'b1;
        waitRfd;
        @(posedge clk) busReq <= '{addr: 8'h14, wrData: 32'h5,
                                   wr: 1'b1, rd: 1'b0};
        @(posedge clk) busReq.wr <= 1'b0;
        rdReg(bpdr_pkg::REG_FUNC_BASE + 8'h4,
              32'(bpdr_pkg::ATTEN_INIT_CODE));
        rdReg(bpdr_pkg::REG_CTRL, 32'h3);
        rdReg(8'h40, 32'h0);
        $display("clear and register test done");
    endtask : t_clear
    initial begin
        reset = 1'b1;
        powerHoldoff_n = 1'b0;
        clearN = 1'b1;
        strap = 1'b0;
        controlBusy = 1'b0;
        busReq = '0;
        n_fail = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_power;
        t_func;
        t_fmcal;
        t_clear;
        finish_test;
    end
    initial begin
        #900_000;
        n_fail++;
        $display("ERROR t=%0t run timed out", $time);
        finish_test;
    end
endmodule : tb_bus_program_delay_router
